/* File: verilog/bmtu_top.sv */
// Bit matrix transpose unit with Avalon-MM slave
// Operation
// - Sixteen row and column registers share addresses; write hits row, read hits column.
// - Rows are write-only, columns read-only.
// - Read-mode bit in control register selects column read data.
// - Read mode 0: column j returns bit j of all rows.
// - Transposed bit k comes from row k.
// - Read mode 1: column read returns stored row value unchanged.
// - Bit-order bit selects arrangement of written word when stored.
// - Bit order 0: word stored unchanged.
// - Bit order 1: word stored bit-reversed.
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "bmtu_defines.svh"
module bmtu_top
  import bmtu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [6:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [1:0]       avs_response
);
  typedef struct packed {
    bmtu_state_e  state;
    bmtu_matrix_t rows;
    logic [1:0]   ctrl;
    logic [31:0]  rdata;
    logic [1:0]   resp;
  } bmtu_regs_s;

  bmtu_regs_s  q_reg;
  bmtu_regs_s  q_next;
  logic [15:0] column;
  logic        is_row;
  logic        is_ctrl;

  function automatic logic [15:0] bmtu_reverse(input logic [15:0] w);
    logic [15:0] r;
    r = '0;
    for (int n = 0; n < 16; n++) begin
      r[15 - n] = w[n];
    end
    return r;
  endfunction

  assign is_row  = (avs_address[6] == 1'b0) && (avs_address[1:0] == 2'h0);
  assign is_ctrl = (avs_address == 7'(`BMTU_CTRL_OFFSET));

  bmtu_matrix_view u_view (
    .rows   (q_reg.rows),
    .index  (avs_address[5:2]),
    .direct (q_reg.ctrl[`BMTU_READ_MODE_BIT]),
    .column (column)
  );

  always_comb begin
    q_next = q_reg;
    unique case (q_reg.state)
      BMTU_IDLE: begin
        if (avs_write) begin
          q_next.state = BMTU_ANSWER;
          q_next.resp  = 2'h0;
          if (is_row) begin
            // Written word goes to a row only
            if (q_reg.ctrl[`BMTU_BIT_ORDER_BIT]) begin
              q_next.rows[avs_address[5:2]] = bmtu_reverse(avs_writedata[15:0]);
            end else begin
              q_next.rows[avs_address[5:2]] = avs_writedata[15:0];
            end
          end else if (is_ctrl) begin
            q_next.ctrl = avs_writedata[1:0];
          end else begin
            q_next.resp = 2'h3;
          end
        end else if (avs_read) begin
          q_next.state = BMTU_ANSWER;
          q_next.resp  = 2'h0;
          if (is_row) begin
            q_next.rdata = {16'h0000, column};
          end else if (is_ctrl) begin
            q_next.rdata = {30'h00000000, q_reg.ctrl};
          end else begin
            q_next.rdata = `BMTU_UNMAPPED_DATA;
            q_next.resp  = 2'h3;
          end
        end
      end
      BMTU_ANSWER: begin
        q_next.state = BMTU_IDLE;
      end
      default: begin
        q_next.state = BMTU_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_reg.state <= BMTU_IDLE;
      q_reg.rows  <= '0;
      q_reg.ctrl  <= `BMTU_CTRL_RESET;
      q_reg.rdata <= 32'h00000000;
      q_reg.resp  <= 2'h0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign avs_waitrequest = (q_reg.state != BMTU_ANSWER);
  assign avs_readdata    = q_reg.rdata;
  assign avs_response    = q_reg.resp;
endmodule // bmtu_top

/* File: include/bmtu_defines.svh */
// Register offsets, field positions and reset values of the bit matrix transpose unit
`ifndef BMTU_DEFINES_SVH
`define BMTU_DEFINES_SVH
`define BMTU_ADDR_W        7
`define BMTU_ROWS          16
`define BMTU_ROW_BASE      7'h00
`define BMTU_ROW_LAST      7'h3c
`define BMTU_CTRL_OFFSET   7'h40
`define BMTU_READ_MODE_BIT 0
`define BMTU_BIT_ORDER_BIT 1
`define BMTU_CTRL_RESET    2'h0
`define BMTU_ROW_RESET     16'h0000
`define BMTU_UNMAPPED_DATA 32'h00000000
`endif

/* File: include/bmtu_pkg.sv */
// Types of the bit matrix transpose unit
package bmtu_pkg;
  typedef logic [15:0] bmtu_word_t;
  typedef logic [15:0][15:0] bmtu_matrix_t;
  typedef enum logic [1:0] {BMTU_IDLE, BMTU_ANSWER} bmtu_state_e;
endpackage

/* File: verilog/bmtu_matrix_view.sv */
// Combinational column view of the row matrix
`timescale 1ns/1ps
module bmtu_matrix_view
  import bmtu_pkg::*;
(
  input  wire bmtu_matrix_t rows,
  input  wire logic [3:0]   index,
  input  wire logic         direct,
  output logic [15:0]       column
);
  logic [15:0] transposed;
  genvar k;
  generate
    for (k = 0; k < 16; k++) begin : g_bit
      assign transposed[k] = rows[k][index];
    end
  endgenerate
  assign column = direct ? rows[index] : transposed;
endmodule // bmtu_matrix_view

/* File: tb/bmtu_monitor.sv */
// Bus timing checker of the bit matrix transpose unit
`timescale 1ns/1ps
module bmtu_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [6:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire req = (avs_read | avs_write) & avs_waitrequest;
  property p_ans; req |=> !avs_waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("long answer");
  property p_unm; req && avs_address[1:0] != 2'h0 |=> avs_response == 2'h3; endproperty
  a_unm: assert property (p_unm) else $error("odd address accepted");
  property p_ok; req && avs_address[1:0] == 2'h0 && avs_address <= 7'h40 |=> avs_response == 2'h0; endproperty
  a_ok: assert property (p_ok) else $error("word refused");
  property p_hi; avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000; endproperty
  a_hi: assert property (p_hi) else $error("upper half set");
  property p_idle; !(avs_read | avs_write) && avs_waitrequest |=> avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  cover property (avs_write && !avs_waitrequest);
  cover property (avs_read && !avs_waitrequest && avs_response == 2'h3);
  cover property (avs_read && !avs_waitrequest && avs_readdata != 32'h0);
endmodule // bmtu_monitor
bind bmtu_top bmtu_monitor i_mon (.*);

/* File: tb/bmtu_host.sv */
// Bus master model of the processor core
`timescale 1ns/1ps
module bmtu_host (
  input  wire logic        clk,
  input  wire logic        wq,
  input  wire logic [31:0] rdq,
  output logic [6:0]       a,
  output logic             rd,
  output logic             wr,
  output logic [31:0]      wd
);
  initial {a, rd, wr, wd} = '0;
  // Whole words at even addresses only
  task automatic acc(input logic w, input logic [6:0] ad, input logic [15:0] d, output logic [15:0] q);
    @(posedge clk);
    a <= ad;
    wr <= w;
    rd <= !w;
    wd <= {16'h0000, d};
    do @(posedge clk); while (wq);
    q = rdq[15:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
endmodule // bmtu_host

/* File: tb/bit_matrix_transpose_unit_test.sv */
// Self-checking bench of the bit matrix transpose unit
`timescale 1ns/1ps
module bit_matrix_transpose_unit_test;
  import bmtu_pkg::*;
  logic clk = 0, rst_n = 0, rd, wr, wq;
  logic [6:0] a;
  logic [31:0] wd, rq;
  logic [1:0] rsp;
  int bad_count = 0, n_checks = 0;
  bmtu_word_t w [16];
  bmtu_word_t q, e;
  initial forever #50 clk = ~clk;
  bmtu_top i_dut (.clk(clk), .rst_n(rst_n), .avs_address(a), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(4'hf), .avs_readdata(rq), .avs_waitrequest(wq), .avs_response(rsp));
  bmtu_host i_host (.clk(clk), .wq(wq), .rdq(rq), .a(a), .rd(rd), .wr(wr), .wd(wd));
  task automatic chk(input bmtu_word_t s, x);
    n_checks++;
    if (s !== x) begin
      bad_count++;
      $display("ERROR readdata exp %h got %h", x, s);
    end
  endtask
  task automatic final_report;
    if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #2000000;
    bad_count++;
    final_report;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 16; k++) w[k] = 16'h9e37 * (k + 1);
    for (int k = 0; k < 16; k++) i_host.acc(1, 7'(4 * k), w[k], q);
    for (int j = 0; j < 16; j++) begin
      for (int k = 0; k < 16; k++) e[k] = w[k][j];
      i_host.acc(0, 7'(4 * j), 16'h0, q);
      chk(q, e);
    end
    i_host.acc(1, 7'h40, 16'h0001, q);
    for (int j = 0; j < 16; j++) begin
      i_host.acc(0, 7'(4 * j), 16'h0, q);
      chk(q, w[j]);
    end
    i_host.acc(1, 7'h40, 16'h0003, q);
    i_host.acc(1, 7'h14, 16'h0001, q);
    i_host.acc(0, 7'h14, 16'h0, q);
    chk(q, 16'h8000);
    i_host.acc(0, 7'h10, 16'h0, q);
    chk(q, w[4]);
    i_host.acc(0, 7'h02, 16'h0, q);
    chk({14'h0, rsp}, 16'h0003);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    i_host.acc(0, 7'h00, 16'h0, q);
    chk(q, 16'h0000);
    final_report;
  end
endmodule // bit_matrix_transpose_unit_test
